// ---- include/mpa_pkg.sv ----
`default_nettype none
package mpa_pkg;
  localparam int NUM_PORTS = 4;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 17;
  localparam int CLK_PERIOD_NS = 25;
  // Release pulse nominal width
  localparam int RELEASE_WIDTH_NS = 260;
  localparam int RELEASE_CYC = (RELEASE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Core cycle length, release to next grant
  localparam int CORE_CYCLE_NS = 600;
  localparam int CORE_CYC = (CORE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] RELEASE_CNT = 8'(RELEASE_CYC);
  localparam logic [7:0] CORE_CNT = 8'(CORE_CYC);
  localparam logic [3:0] MASK_NONE = 4'h0;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  typedef enum logic [1:0] {
    MPA_IDLE = 2'b00,
    MPA_RELEASE = 2'b01,
    MPA_RECOVER = 2'b11
  } mpa_state_e;
endpackage
`default_nettype wire

// ---- logic/mpa_arbiter.sv ----
// Behaviour
// - Every write stores a full word plus its parity bit; no partial writes.
// - Static selector picks normal fair mode or straight fixed-priority mode.
// - Normal mode serves a simultaneous group highest first, all before newcomers.
// - Straight mode always grants the highest-priority requesting port.
// - A disabled port's requests are ignored entirely.
// - Idle module returns release at the nominal point of its cycle.
// - Busy module delays release to a later clock period.
// - Nonexistent address gives no address-here and never a release.
`timescale 1ns/1ps
`default_nettype none
module mpa_arbiter (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Static selectors
  input wire logic straight_priority_in,
  input wire logic [3:0] port_disable_in,
  // Per-port requests (port 0 highest priority)
  input wire logic [3:0] memory_request_in,
  input wire logic [15:0] word_address_lines_in [4],
  input wire logic [3:0] read_write_select_in,
  input wire logic [16:0] write_data_with_parity_in [4],
  // Address window of existing memory, in words
  input wire logic [15:0] memory_top_in,
  // Per-port answers
  output logic [3:0] address_here_response_out,
  output logic [3:0] request_release_out,
  output logic [16:0] read_data_with_parity_out,
  // Core array access
  output logic core_write_out,
  output logic core_read_out,
  output logic [15:0] core_address_out,
  output logic [16:0] core_write_data_out,
  input wire logic [16:0] core_read_data_in
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [3:0] req_meta, req_sync, dis_meta, dis_sync;
  logic mode_meta, mode_sync;
  logic [3:0] rw_meta, rw_sync;
  logic [15:0] top_meta, top_sync;
  logic [15:0] addr_meta [4];
  logic [15:0] addr_sync [4];
  logic [16:0] wdata_meta [4];
  logic [16:0] wdata_sync [4];
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      req_meta <= mpa_pkg::MASK_NONE;
      req_sync <= mpa_pkg::MASK_NONE;
      dis_meta <= mpa_pkg::MASK_NONE;
      dis_sync <= mpa_pkg::MASK_NONE;
      mode_meta <= 1'b0;
      mode_sync <= 1'b0;
      rw_meta <= mpa_pkg::MASK_NONE;
      rw_sync <= mpa_pkg::MASK_NONE;
      top_meta <= mpa_pkg::WORD_RESET;
      top_sync <= mpa_pkg::WORD_RESET;
      for (int i = 0; i < 4; i++) begin
        addr_meta[i] <= mpa_pkg::WORD_RESET;
        addr_sync[i] <= mpa_pkg::WORD_RESET;
        wdata_meta[i] <= {1'b0, mpa_pkg::WORD_RESET};
        wdata_sync[i] <= {1'b0, mpa_pkg::WORD_RESET};
      end
    end else begin
      req_meta <= memory_request_in;
      req_sync <= req_meta;
      dis_meta <= port_disable_in;
      dis_sync <= dis_meta;
      mode_meta <= straight_priority_in;
      mode_sync <= mode_meta;
      rw_meta <= read_write_select_in;
      rw_sync <= rw_meta;
      top_meta <= memory_top_in;
      top_sync <= top_meta;
      for (int i = 0; i < 4; i++) begin
        addr_meta[i] <= word_address_lines_in[i];
        addr_sync[i] <= addr_meta[i];
        wdata_meta[i] <= write_data_with_parity_in[i];
        wdata_sync[i] <= wdata_meta[i];
      end
    end
  end

  // ----------------------------------------
  // Address decode per port
  // ----------------------------------------
  // Address passes the same two flops as the request, so both line up
  logic [3:0] live, exists;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_port
      assign exists[gi] = addr_sync[gi] <= top_sync;
      assign live[gi] = req_sync[gi] & ~dis_sync[gi] & exists[gi];
    end
  endgenerate

  // ----------------------------------------
  // Arbitration state
  // ----------------------------------------
  mpa_pkg::mpa_state_e state, next_state;
  logic [3:0] group, next_group, grant, next_grant;
  logic [7:0] cnt, next_cnt;
  logic [3:0] release_r, next_release;
  logic [3:0] here, next_here;
  logic [16:0] rdata, next_rdata;
  logic cwr, next_cwr, crd, next_crd;
  logic [15:0] caddr, next_caddr;
  logic [16:0] cwdata, next_cwdata;
  logic [3:0] pool, pick;

  always_comb begin
    // Normal mode draws only from the frozen group until it drains
    if (mode_sync)
      pool = live;
    else if ((live & group) != mpa_pkg::MASK_NONE)
      pool = live & group;
    else
      pool = live;
    pick = pool & (~pool + 4'h1); // lowest index wins
  end

  always_comb begin
    next_state = state;
    next_group = group;
    next_grant = grant;
    next_cnt = cnt;
    next_release = mpa_pkg::MASK_NONE;
    next_here = live;
    next_rdata = rdata;
    next_cwr = 1'b0;
    next_crd = 1'b0;
    next_caddr = caddr;
    next_cwdata = cwdata;
    case (state)
      mpa_pkg::MPA_IDLE: begin
        next_rdata = {1'b0, mpa_pkg::WORD_RESET};
        if (pick != mpa_pkg::MASK_NONE) begin
          // Grant latched; release comes at the nominal point of this cycle
          next_grant = pick;
          // Withdrawn members leave the group, so an abort cannot stall it
          if (!mode_sync && (live & group) == mpa_pkg::MASK_NONE)
            next_group = live & ~pick;
          else
            next_group = group & live & ~pick;
          next_state = mpa_pkg::MPA_RELEASE;
          next_cnt = mpa_pkg::RELEASE_CNT;
          for (int i = 0; i < 4; i++) begin
            if (pick[i]) begin
              next_caddr = addr_sync[i];
              next_cwdata = wdata_sync[i];
              next_cwr = ~rw_sync[i];
              next_crd = rw_sync[i];
            end
          end
        end
      end
      mpa_pkg::MPA_RELEASE: begin
        next_release = grant;
        if (cnt == mpa_pkg::RELEASE_CNT)
          next_rdata = core_read_data_in;
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h01) begin
          // Release stands on the last count too, giving the full width
          next_state = mpa_pkg::MPA_RECOVER;
          next_cnt = mpa_pkg::CORE_CNT - mpa_pkg::RELEASE_CNT;
        end
      end
      mpa_pkg::MPA_RECOVER: begin
        // Others wait here, so a busy module releases them later
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h01) begin
          next_state = mpa_pkg::MPA_IDLE;
          next_grant = mpa_pkg::MASK_NONE;
        end
      end
      default: begin
        next_state = mpa_pkg::MPA_IDLE;
        next_grant = mpa_pkg::MASK_NONE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state <= mpa_pkg::MPA_IDLE;
      group <= mpa_pkg::MASK_NONE;
      grant <= mpa_pkg::MASK_NONE;
      cnt <= 8'h00;
      release_r <= mpa_pkg::MASK_NONE;
      here <= mpa_pkg::MASK_NONE;
      rdata <= 17'h00000;
      cwr <= 1'b0;
      crd <= 1'b0;
      caddr <= 16'h0000;
      cwdata <= 17'h00000;
    end else begin
      state <= next_state;
      group <= next_group;
      grant <= next_grant;
      cnt <= next_cnt;
      release_r <= next_release;
      here <= next_here;
      rdata <= next_rdata;
      cwr <= next_cwr;
      crd <= next_crd;
      caddr <= next_caddr;
      cwdata <= next_cwdata;
    end
  end

  assign address_here_response_out = here;
  assign request_release_out = release_r;
  assign read_data_with_parity_out = rdata;
  assign core_write_out = cwr;
  assign core_read_out = crd;
  assign core_address_out = caddr;
  assign core_write_data_out = cwdata;
endmodule
`default_nettype wire

// ---- tb/mpa_arbiter_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------
// Port answer checks
// ------------------
module mpa_arbiter_chk (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [3:0] port_disable_in,
  input wire logic [3:0] memory_request_in,
  input wire logic [3:0] address_here_response_out,
  input wire logic [3:0] request_release_out,
  input wire logic core_write_out,
  input wire logic core_read_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  wire logic rel = |request_release_out;
  wire logic core = core_read_out | core_write_out;
  sequence s_hold; ##10 rel ##1 !rel; endsequence
  sequence s_gap; !rel [*8]; endsequence
  a_one_grant: assert property ($onehot0(request_release_out))
    else $error("two releases at once");
  a_disabled_quiet: assert property (!(|((request_release_out |
    address_here_response_out) & port_disable_in))) else $error("disabled port answered");
  a_release_here: assert property ($rose(rel) |->
    |(request_release_out & $past(address_here_response_out))) else $error("release w/o here");
  a_release_width: assert property ($rose(rel) |-> s_hold)
    else $error("release width wrong");
  a_core_first: assert property ($rose(rel) |-> $past(core))
    else $error("release without core cycle");
  a_core_pulse: assert property (core |=> !core ##1 !core)
    else $error("core strobe too long");
  a_busy_gap: assert property ($fell(rel) |-> s_gap)
    else $error("release too soon after last");
  a_here_cause: assert property (!(|(address_here_response_out
    & ~$past(memory_request_in, 3)))) else $error("here without request");
endmodule
bind mpa_arbiter mpa_arbiter_chk i_chk (.clk_in(clk_in), .nrst_in(nrst_in),
  .port_disable_in(port_disable_in), .memory_request_in(memory_request_in),
  .address_here_response_out(address_here_response_out),
  .request_release_out(request_release_out), .core_write_out(core_write_out),
  .core_read_out(core_read_out));
`default_nettype wire

// ---- tb/mpa_port_user.sv ----
`timescale 1ns/1ps
`default_nettype none
// ---------------
// Port user model
// ---------------
module mpa_port_user (
  input wire logic clk_in,
  input wire logic [3:0] start_in,
  input wire logic [3:0] release_in,
  input wire logic [3:0] here_in,
  output logic [3:0] request_out,
  output logic [3:0] abort_out
);
  logic [3:0] wait_cnt [4] = '{4'h0, 4'h0, 4'h0, 4'h0};
  initial request_out = 4'h0;
  initial abort_out = 4'h0;
  always @(posedge clk_in) begin
    for (int i = 0; i < 4; i++) begin
      if (start_in[i]) begin
        request_out[i] <= 1'b1;
        abort_out[i] <= 1'b0;
        wait_cnt[i] <= 4'h0;
      end else if (release_in[i]) request_out[i] <= 1'b0;
      else if (request_out[i] && !here_in[i]) begin
        wait_cnt[i] <= wait_cnt[i] + 4'h1;
        // Escape a hung request on missing memory
        if (wait_cnt[i] == 4'h8) begin
          request_out[i] <= 1'b0;
          abort_out[i] <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/mpa_arbiter_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module mpa_arbiter_test;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic straight = 1'b0;
  logic [3:0] dis = 4'h0, rw = 4'hF, start = 4'h0, here, rel, req, abort;
  logic [15:0] addr [4];
  logic [16:0] wdata [4];
  logic [16:0] rdata, cwdata, crdata;
  logic [15:0] caddr;
  int fails = 0, total_checks = 0;
  always #12.5 clk_in = ~clk_in;
  assign crdata = {~^caddr, caddr};
  mpa_arbiter i_dut (.clk_in(clk_in), .nrst_in(nrst_in), .straight_priority_in(straight),
    .port_disable_in(dis), .memory_request_in(req), .word_address_lines_in(addr),
    .read_write_select_in(rw), .write_data_with_parity_in(wdata), .memory_top_in(16'h7FFF),
    .address_here_response_out(here), .request_release_out(rel),
    .read_data_with_parity_out(rdata), .core_write_out(), .core_read_out(),
    .core_address_out(caddr), .core_write_data_out(cwdata), .core_read_data_in(crdata));
  mpa_port_user i_user (.clk_in(clk_in), .start_in(start), .release_in(rel),
    .here_in(here), .request_out(req), .abort_out(abort));
  // --------------
  // Shared helpers
  // --------------
  task automatic check(input logic [16:0] seen, input logic [16:0] want);
    total_checks++;
    if (seen !== want) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task automatic close_out;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic go(input logic [3:0] m);
    @(posedge clk_in) start <= m;
    @(posedge clk_in) start <= 4'h0;
  endtask
  // Leaves the caller on a clock edge, release already over
  task automatic wait_rel(output int p, output int n);
    n = 0;
    while (!(|rel)) begin
      @(posedge clk_in) #1;
      n++;
      if (n > 200) begin
        fails++;
        close_out();
      end
    end
    p = $clog2(rel);
    repeat (12) @(posedge clk_in);
  endtask
  // ---------
  // Scenarios
  // ---------
  task automatic t_rmw;
    int p, n;
    logic [16:0] w;
    addr[1] <= 16'h0123;
    w = 17'h00000;
    go(4'h2);
    wait_rel(p, n);
    check(17'(n), 17'h4);
    check(rdata, {~^16'h0123, 16'h0123});
    w = rdata;
    w[7:0] = 8'hA5;
    w[16] = ~^w[15:0];
    rw[1] <= 1'b0;
    wdata[1] <= w;
    repeat (16) @(posedge clk_in);
    go(4'h2);
    wait_rel(p, n);
    check(cwdata, w);
    rw[1] <= 1'b1;
  endtask
  task automatic t_order(input logic mode, input logic [7:0] want);
    int p, n;
    logic [7:0] got;
    straight <= mode;
    repeat (20) @(posedge clk_in);
    go(4'hE);
    wait_rel(p, n);
    got = 8'(p);
    go(4'h1);
    for (int k = 1; k < 4; k++) begin
      wait_rel(p, n);
      got = {got[5:0], 2'(p)};
    end
    check(17'(got), 17'(want));
  endtask
  task automatic t_refuse;
    dis <= 4'h4;
    addr[3] <= 16'h8000;
    repeat (20) @(posedge clk_in);
    go(4'hC);
    repeat (40) @(posedge clk_in) #1;
    check(17'(rel | here), 17'h0);
    check(17'(abort), 17'hC);
  endtask
  initial begin
    for (int i = 0; i < 4; i++) begin
      addr[i] = 16'(i);
      wdata[i] = 17'h0;
    end
    repeat (5) @(posedge clk_in);
    nrst_in <= 1'b1;
    t_rmw();
    t_order(1'b0, 8'h6C);
    t_order(1'b1, 8'h4B);
    t_refuse();
    close_out();
  end
endmodule
`default_nettype wire
